// ### hdl/tio_io_glue.sv
`timescale 1ns/1ps
module tio_io_glue #(
    parameter int NAME_HOLD_CYCLES = tio_pkg::NAME_HOLD_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic cpu_iorq_n_in,
    input wire logic cpu_mreq_n_in,
    input wire logic cpu_rd_n_in,
    input wire logic cpu_wr_n_in,
    input wire logic cpu_m1_n_in,
    input wire logic [7:0] cpu_data_in,
    output logic [7:0] cpu_data_out,
    output logic cpu_data_oe_out,
    output logic rom_sel_n_out,
    output logic exp_sel_n_out,
    output logic ram_sel_n_out,
    output logic counter_timer_device_sel_n_out,
    output logic aux_parallel_device_sel_n_out,
    input wire logic [35:0] keys_in,
    input wire logic fn_key_n_in,
    input wire logic recorder_output_jack_in,
    output logic recorder_input_jack_out,
    output logic speaker_out,
    output logic tone_led_on_out,
    output logic [7:0] segment_out,
    output logic [5:0] column_out,
    output logic break_ctl_out,
    input wire logic tape_save_in,
    input wire logic tape_load_in,
    input wire logic tape_byte_stb_in,
    input wire logic [7:0] tape_byte_in,
    input wire logic tape_check_clr_in,
    input wire logic tape_check_done_in,
    input wire logic [7:0] tape_check_exp_in,
    output logic tape_hdr_done_out,
    output logic tape_check_ok_out,
    output logic tape_check_err_out,
    input wire logic name_show_in,
    output logic name_hold_out
);
    typedef struct packed {
        logic [15:0] addr_s1;
        logic [15:0] addr_s2;
        logic [4:0] ctl_s1;
        logic [4:0] ctl_s2;
        logic [7:0] data_s1;
        logic [7:0] data_s2;
        logic tape_s1;
        logic tape_s2;
        logic fn_s1;
        logic fn_s2;
        logic wr_prev;
        logic [7:0] ctrl;
        logic [7:0] seg;
        logic [7:0] col;
        logic [7:0] rdata;
        logic oe;
        logic [31:0] hold_cnt;
        logic [7:0] sum;
        logic [2:0] hdr_cnt;
        logic chk_ok;
        logic chk_err;
    } tio_glue_state_t;

    tio_glue_state_t q;
    tio_glue_state_t d;
    tio_sel_if sel_if ();
    logic [5:0] rows_n;
    logic io_wr;
    logic wr_edge;
    logic io_rd;
    logic mem_rd;
    logic int_ack;
    logic ppi_rd;

    tio_addr_decode u_decode (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .addr_in(q.addr_s2),
        .io_req_in(q.ctl_s2[tio_pkg::CTL_IORQ] && !q.ctl_s2[tio_pkg::CTL_M1]),
        .mem_req_in(q.ctl_s2[tio_pkg::CTL_MREQ]),
        .sel(sel_if.dec)
    );

    tio_key_sense u_keys (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .keys_in(keys_in),
        .cols_in(column_out),
        .rows_n_out(rows_n)
    );

    always_comb
    begin
        io_wr = q.ctl_s2[tio_pkg::CTL_IORQ] && q.ctl_s2[tio_pkg::CTL_WR];
        wr_edge = io_wr && !q.wr_prev;
        io_rd = q.ctl_s2[tio_pkg::CTL_IORQ] && q.ctl_s2[tio_pkg::CTL_RD];
        mem_rd = q.ctl_s2[tio_pkg::CTL_MREQ] && q.ctl_s2[tio_pkg::CTL_RD];
        int_ack = q.ctl_s2[tio_pkg::CTL_IORQ] && q.ctl_s2[tio_pkg::CTL_M1];
        ppi_rd = io_rd && sel_if.ppi_sel && (sel_if.reg_idx != tio_pkg::REG_CONTROL);
    end

    always_comb
    begin
        d = q;
        // Bus pins are asynchronous to clk_in; strobes inverted to active high
        d.addr_s1 = cpu_addr_in;
        d.addr_s2 = q.addr_s1;
        d.ctl_s1 = ~{cpu_m1_n_in, cpu_wr_n_in, cpu_rd_n_in, cpu_mreq_n_in, cpu_iorq_n_in};
        d.ctl_s2 = q.ctl_s1;
        d.data_s1 = cpu_data_in;
        d.data_s2 = q.data_s1;
        d.tape_s1 = recorder_output_jack_in;
        d.tape_s2 = q.tape_s1;
        d.fn_s1 = fn_key_n_in;
        d.fn_s2 = q.fn_s1;
        d.wr_prev = io_wr;

        // Writes act once per strobe, on its leading edge
        if (wr_edge && sel_if.ppi_sel)
        begin
            case (sel_if.reg_idx)
                tio_pkg::REG_SEGMENT_DRIVE: d.seg = q.data_s2;
                tio_pkg::REG_COLUMN_TAPE_OUT: d.col = q.data_s2;
                tio_pkg::REG_CONTROL: d.ctrl = q.data_s2;
                default: d.ctrl = q.ctrl;
            endcase
        end

        d.oe = int_ack || (io_rd && !sel_if.ctc_sel && !sel_if.aux_sel) ||
               (mem_rd && !sel_if.rom_sel && !sel_if.exp_sel && !sel_if.ram_sel);
        d.rdata = tio_pkg::BUS_PULLUP;
        if (ppi_rd)
        begin
            case (sel_if.reg_idx)
                tio_pkg::REG_KEYPAD_ROW_TAPE_IN: d.rdata = {q.tape_s2, q.fn_s2, rows_n};
                tio_pkg::REG_SEGMENT_DRIVE: d.rdata = q.seg;
                tio_pkg::REG_COLUMN_TAPE_OUT: d.rdata = q.col;
                default: d.rdata = tio_pkg::BUS_PULLUP;
            endcase
        end

        if (name_show_in)
            d.hold_cnt = 32'(NAME_HOLD_CYCLES);
        else if (q.hold_cnt != 32'h0)
            d.hold_cnt = q.hold_cnt - 32'h1;

        // Clear wins over a byte in the same cycle: a new file is starting
        if (tape_check_clr_in)
        begin
            d.sum = 8'h00;
            d.hdr_cnt = 3'h0;
            d.chk_ok = 1'b0;
            d.chk_err = 1'b0;
        end
        else if (tape_byte_stb_in)
        begin
            if (q.hdr_cnt != 3'(tio_pkg::HDR_BYTES))
                d.hdr_cnt = q.hdr_cnt + 3'h1;
            else
                d.sum = q.sum + tape_byte_in;
        end

        // checksum compare
        // A result beats a clear in the same cycle, so a finished load is never lost
        if (tape_check_done_in)
        begin
            d.chk_ok = (q.sum == tape_check_exp_in);
            d.chk_err = (q.sum != tape_check_exp_in);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            q <= '0;
            q.ctrl <= tio_pkg::CTRL_WORD_RST;
            q.seg <= tio_pkg::SEG_RST;
            q.col <= tio_pkg::COL_RST;
        end
        else
            q <= d;
    end

    assign cpu_data_out = q.rdata;
    assign cpu_data_oe_out = q.oe;
    assign rom_sel_n_out = !sel_if.rom_sel;
    assign exp_sel_n_out = !sel_if.exp_sel;
    assign ram_sel_n_out = !sel_if.ram_sel;
    assign counter_timer_device_sel_n_out = !sel_if.ctc_sel;
    assign aux_parallel_device_sel_n_out = !sel_if.aux_sel;
    assign recorder_input_jack_out = q.col[tio_pkg::BIT_TAPE_OUT];
    assign speaker_out = tape_load_in ? q.tape_s2 : q.col[tio_pkg::BIT_TAPE_OUT];
    assign tone_led_on_out = !q.col[tio_pkg::BIT_TAPE_OUT];
    assign break_ctl_out = q.col[tio_pkg::BIT_BREAK];
    assign segment_out = tape_save_in ? 8'h00 : q.seg;
    assign column_out = tape_save_in ? 6'h00 : q.col[5:0];
    assign tape_hdr_done_out = (q.hdr_cnt == 3'(tio_pkg::HDR_BYTES));
    assign tape_check_ok_out = q.chk_ok;
    assign tape_check_err_out = q.chk_err;
    assign name_hold_out = (q.hold_cnt != 32'h0);

    chk_seg_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_edge && sel_if.ppi_sel && sel_if.reg_idx == 2'h1 |=> q.seg == $past(q.data_s2))
        else $error("segment write not stored");
    chk_led_tone: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !q.col[7] |-> tone_led_on_out && !recorder_input_jack_out)
        else $error("tone led not lit for bit 7 low");
    chk_pullup_ff: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        int_ack |=> cpu_data_oe_out && cpu_data_out == 8'hFF)
        else $error("bus not pulled to ones on acknowledge");
    chk_port_a_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ppi_rd && sel_if.reg_idx == 2'h0 |=> cpu_data_oe_out &&
        cpu_data_out[7] == $past(q.tape_s2) && cpu_data_out[6] == $past(q.fn_s2))
        else $error("input port tape or key bit wrong");
    chk_save_blank: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_save_in |-> segment_out == 8'h00 && column_out == 6'h00)
        else $error("display not blank while saving");
    chk_load_echo: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_load_in |-> speaker_out == q.tape_s2)
        else $error("tape input not echoed");
    chk_hold_name: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        name_show_in |=> name_hold_out [*8])
        else $error("name hold ended early");
    chk_check_result: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_check_done_in |=> tape_check_ok_out != tape_check_err_out)
        else $error("check result not exclusive");
    chk_hdr_count: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_byte_stb_in && !tape_check_clr_in && !tape_hdr_done_out |=> $stable(q.sum))
        else $error("header byte added to check");
    chk_hdr_last: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_byte_stb_in && !tape_check_clr_in &&
        q.hdr_cnt == 3'(tio_pkg::HDR_BYTES - 1) |=> tape_hdr_done_out)
        else $error("header end not flagged");
    chk_sum_add: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_byte_stb_in && !tape_check_clr_in && tape_hdr_done_out |=>
        q.sum == 8'($past(q.sum) + $past(tape_byte_in)))
        else $error("data byte not added to check");
    chk_hold_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        name_show_in |=>
        q.hold_cnt == 32'(NAME_HOLD_CYCLES))
        else $error("name hold not restarted");

    chk_col_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_edge && sel_if.ppi_sel && sel_if.reg_idx == tio_pkg::REG_COLUMN_TAPE_OUT |=>
        q.col == $past(q.data_s2))
        else $error("column write not stored");
    chk_in_port_ro: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_edge && sel_if.ppi_sel && sel_if.reg_idx == tio_pkg::REG_KEYPAD_ROW_TAPE_IN |=>
        $stable(q.seg) && $stable(q.col))
        else $error("write to input port changed an output port");
    chk_rows_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        ppi_rd && sel_if.reg_idx == tio_pkg::REG_KEYPAD_ROW_TAPE_IN |=>
        cpu_data_out[5:0] == $past(rows_n))
        else $error("row bits not on input port");
    chk_save_tone: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_save_in && !tape_load_in |->
        speaker_out == recorder_input_jack_out && tone_led_on_out == !recorder_input_jack_out)
        else $error("tone not following tape out while saving");

    // Reads that nothing answers must look like the pull-ups
    chk_io_pullup: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        io_rd && !sel_if.ppi_sel && !sel_if.ctc_sel && !sel_if.aux_sel |=>
        cpu_data_oe_out && cpu_data_out == tio_pkg::BUS_PULLUP)
        else $error("unanswered io read not all ones");
    chk_mem_pullup: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        mem_rd && !sel_if.rom_sel && !sel_if.exp_sel && !sel_if.ram_sel |=>
        cpu_data_oe_out && cpu_data_out == tio_pkg::BUS_PULLUP)
        else $error("unmapped memory read not all ones");

    cov_seg_write: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        wr_edge && sel_if.ppi_sel && sel_if.reg_idx == 2'h1);
    cov_key_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        ppi_rd && rows_n != 6'h3F);
    cov_check_err: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        tape_check_err_out);
    cov_int_ack: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        int_ack ##1 cpu_data_oe_out);
    cov_name_hold: cover property (@(posedge clk_in) disable iff (!rst_n_in)
        name_show_in ##1 name_hold_out);
endmodule // tio_io_glue

// ### hdl/tio_pkg.sv
package tio_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int ROWS = 6;
    localparam int COLS = 6;
    localparam int KEYS = ROWS * COLS;

    // I/O group in address bits 7:6, register index in bits 1:0
    localparam logic [1:0] IO_GRP_PPI = 2'h0;
    localparam logic [1:0] IO_GRP_CTC = 2'h1;
    localparam logic [1:0] IO_GRP_AUX = 2'h2;
    localparam logic [1:0] REG_KEYPAD_ROW_TAPE_IN = 2'h0;
    localparam logic [1:0] REG_SEGMENT_DRIVE = 2'h1;
    localparam logic [1:0] REG_COLUMN_TAPE_OUT = 2'h2;
    localparam logic [1:0] REG_CONTROL = 2'h3;

    // Memory map of the board
    localparam logic [15:0] ROM_LO = 16'h0000;
    localparam logic [15:0] ROM_HI = 16'h07FF;
    localparam logic [15:0] EXP_LO = 16'h0800;
    localparam logic [15:0] EXP_HI = 16'h0FFF;
    localparam logic [15:0] RAM_LO = 16'h1800;
    localparam logic [15:0] RAM_HI = 16'h1FFF;

    localparam logic [7:0] CTRL_WORD_RST = 8'h00;
    localparam logic [7:0] SEG_RST = 8'h00;
    localparam logic [7:0] COL_RST = 8'h00;
    localparam logic [7:0] BUS_PULLUP = 8'hFF;

    // Field positions, and the control field width
    localparam int BIT_TAPE_IN = 7;
    localparam int BIT_FN_KEY = 6;
    localparam int BIT_TAPE_OUT = 7;
    localparam int BIT_BREAK = 6;
    localparam int CTL_IORQ = 0;
    localparam int CTL_MREQ = 1;
    localparam int CTL_RD = 2;
    localparam int CTL_WR = 3;
    localparam int CTL_M1 = 4;
    localparam int CTL_W = 5;

    // Tape file header: name, start and end, two bytes each
    localparam int HDR_BYTES = 6;

    localparam int CLK_MHZ = 200;
    localparam int NAME_HOLD_MS = 1500;
    localparam int NAME_HOLD_CYC = NAME_HOLD_MS * CLK_MHZ * 1000;
endpackage

// ### hdl/tio_sel_if.sv
`timescale 1ns/1ps
interface tio_sel_if;
    logic ppi_sel;
    logic ctc_sel;
    logic aux_sel;
    logic rom_sel;
    logic exp_sel;
    logic ram_sel;
    logic [1:0] reg_idx;

    modport dec (
        output ppi_sel, ctc_sel, aux_sel, rom_sel, exp_sel, ram_sel, reg_idx
    );
    modport top (
        input ppi_sel, ctc_sel, aux_sel, rom_sel, exp_sel, ram_sel, reg_idx
    );
endinterface

// ### hdl/tio_addr_decode.sv
`timescale 1ns/1ps
module tio_addr_decode (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] addr_in,
    input wire logic io_req_in,
    input wire logic mem_req_in,
    tio_sel_if.dec sel
);
    logic [1:0] grp;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    always_comb
    begin
        grp = addr_in[7:6];
        sel.reg_idx = addr_in[1:0];
        sel.ppi_sel = io_req_in && (grp == tio_pkg::IO_GRP_PPI);
        sel.ctc_sel = io_req_in && (grp == tio_pkg::IO_GRP_CTC);
        sel.aux_sel = io_req_in && (grp == tio_pkg::IO_GRP_AUX);
        sel.rom_sel = mem_req_in && in_range(addr_in, tio_pkg::ROM_LO, tio_pkg::ROM_HI);
        sel.exp_sel = mem_req_in && in_range(addr_in, tio_pkg::EXP_LO, tio_pkg::EXP_HI);
        sel.ram_sel = mem_req_in && in_range(addr_in, tio_pkg::RAM_LO, tio_pkg::RAM_HI);
    end

    chk_io_alias_ppi: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        io_req_in && addr_in[7:6] == 2'h0 |-> sel.ppi_sel && sel.reg_idx == addr_in[1:0])
        else $error("ppi not selected on aliased address");
    chk_mem_one_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $onehot0({sel.rom_sel, sel.exp_sel, sel.ram_sel}) &&
        (!sel.ram_sel || (mem_req_in && addr_in[15:11] == tio_pkg::RAM_LO[15:11])))
        else $error("memory selects overlap");
    chk_ctc_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sel.ctc_sel |-> io_req_in && addr_in[7:6] == 2'h1 && !sel.ppi_sel)
        else $error("counter timer selected outside its range");
    chk_aux_range: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sel.aux_sel |-> io_req_in && addr_in[7:6] == 2'h2 && !sel.ctc_sel)
        else $error("aux parallel selected outside its range");
endmodule // tio_addr_decode

// ### hdl/tio_key_sense.sv
`timescale 1ns/1ps
module tio_key_sense #(
    parameter int ROWS = tio_pkg::ROWS,
    parameter int COLS = tio_pkg::COLS
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [ROWS*COLS-1:0] keys_in,
    input wire logic [COLS-1:0] cols_in,
    output logic [ROWS-1:0] rows_n_out
);
    typedef struct packed {
        logic [ROWS*COLS-1:0] s1;
        logic [ROWS*COLS-1:0] s2;
    } tio_key_state_t;

    tio_key_state_t q;
    tio_key_state_t d;

    always_comb
    begin
        d = q;
        d.s1 = keys_in;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            q <= '0;
        else
            q <= d;
    end

    // Keys are switches between a column and a row; only driven columns pull rows low
    genvar r;
    generate
        for (r = 0; r < ROWS; r++)
        begin : g_row
            assign rows_n_out[r] = ~|(q.s2[r*COLS +: COLS] & cols_in);
        end
    endgenerate

    chk_rows_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (cols_in == '0 || q.s2 == '0) |-> rows_n_out == '1)
        else $error("row low with no pressed key in a driven column");
endmodule // tio_key_sense

// ### tb/tio_far_model.sv
`timescale 1ns/1ps
module tio_far_model (
    input wire logic [5:0] press_idx_in,
    input wire logic fn_press_in,
    input wire logic tape_lvl_in,
    output logic [35:0] keys_out,
    output logic fn_key_n_out,
    output logic tape_out
);
    // static switch closure
    // Column gating is the design's job, so a closed switch stays high
    always_comb
    begin
        keys_out = 36'h0;
        if (press_idx_in < 6'd36)
        begin
            keys_out[press_idx_in] = 1'b1;
        end
    end
    assign fn_key_n_out = ~fn_press_in;
    assign tape_out = tape_lvl_in;
endmodule // tio_far_model

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    localparam int HOLD = 20;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic iorq_n = 1'b1, mreq_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, m1_n = 1'b1;
    logic [7:0] wdat = 8'h00, tbyte = 8'h00, texp = 8'h00;
    logic [5:0] press = 6'h3F;
    logic fn_press = 1'b0, tape_lvl = 1'b0, save = 1'b0, load = 1'b0;
    logic stb = 1'b0, clr = 1'b0, done = 1'b0, show = 1'b0;
    logic [7:0] dout, seg, r;
    logic oe, rom_n, exp_n, ram_n, ctc_n, aux_n, jack, spk, led, brk, hdr, ok, err, hold;
    logic [5:0] col, s;
    logic [35:0] keys;
    logic fn_n, tape;
    logic [7:0] io_a [7] = '{8'h40, 8'h43, 8'h7C, 8'h80, 8'h83, 8'hBF, 8'h01};
    logic [15:0] mem_a [10] = '{16'h0000, 16'h07FF, 16'h0800, 16'h0FFF, 16'h1000,
        16'h17FF, 16'h1800, 16'h1FFF, 16'h2000, 16'hF800};
    logic [2:0] mem_e [10] = '{3'h3, 3'h3, 3'h5, 3'h5, 3'h7, 3'h7, 3'h6, 3'h6, 3'h7, 3'h7};
    int err_total = 0;
    int n_tests = 0;
    int cnt;

    always #2.5 clk_in = ~clk_in;

    tio_io_glue #(.NAME_HOLD_CYCLES(HOLD)) tio_io_glue_inst (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(addr),
        .cpu_iorq_n_in(iorq_n), .cpu_mreq_n_in(mreq_n), .cpu_rd_n_in(rd_n),
        .cpu_wr_n_in(wr_n), .cpu_m1_n_in(m1_n), .cpu_data_in(wdat),
        .cpu_data_out(dout), .cpu_data_oe_out(oe), .rom_sel_n_out(rom_n),
        .exp_sel_n_out(exp_n), .ram_sel_n_out(ram_n),
        .counter_timer_device_sel_n_out(ctc_n), .aux_parallel_device_sel_n_out(aux_n),
        .keys_in(keys), .fn_key_n_in(fn_n), .recorder_output_jack_in(tape),
        .recorder_input_jack_out(jack), .speaker_out(spk), .tone_led_on_out(led),
        .segment_out(seg), .column_out(col), .break_ctl_out(brk),
        .tape_save_in(save), .tape_load_in(load), .tape_byte_stb_in(stb),
        .tape_byte_in(tbyte), .tape_check_clr_in(clr), .tape_check_done_in(done),
        .tape_check_exp_in(texp), .tape_hdr_done_out(hdr), .tape_check_ok_out(ok),
        .tape_check_err_out(err), .name_show_in(show), .name_hold_out(hold)
    );

    tio_far_model tio_far_model_inst (
        .press_idx_in(press), .fn_press_in(fn_press), .tape_lvl_in(tape_lvl),
        .keys_out(keys), .fn_key_n_out(fn_n), .tape_out(tape)
    );

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // Kind 0 io read, 1 io write, 2 memory read, 3 interrupt acknowledge
    // Strobes held four edges, released three, to clear the pin synchroniser
    task automatic bus(input logic [15:0] a, input int k, input logic [7:0] d);
        tk(1);
        addr = a;
        wdat = d;
        iorq_n = (k == 2);
        mreq_n = (k != 2);
        rd_n = !(k == 0 || k == 2);
        wr_n = (k != 1);
        m1_n = (k != 3);
        tk(4);
        r = oe ? dout : 8'h00;
        s = {oe, rom_n, exp_n, ram_n, ctc_n, aux_n};
        {iorq_n, mreq_n, rd_n, wr_n, m1_n} = 5'h1F;
        tk(3);
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        tk(1);
        sig = 1'b0;
    endtask

    task automatic wrap_up;
        if (err_total == 0 && n_tests > 0)
        begin
            $display("TB: PASS");
        end
        else
        begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial
    begin
        #50000;
        err_total++;
        wrap_up();
    end

    initial
    begin
        tk(3);
        rst_n_in = 1'b1;
        tk(1);
        chk8(seg, 8'h00);
        chk8({oe, led, spk, brk, rom_n, ram_n, ctc_n, aux_n}, 8'h4F);
        bus(16'h0003, 1, 8'h03);
        bus(16'h0001, 1, 8'hA5);
        chk8(seg, 8'hA5);
        bus(16'h003D, 1, 8'h5A);
        chk8(seg, 8'h5A);
        bus(16'h0001, 0, 8'h00);
        chk8(r, 8'h5A);
        bus(16'h0000, 1, 8'h77);
        chk8(seg, 8'h5A);
        bus(16'h0002, 1, 8'h81);
        chk8({2'h0, col}, 8'h01);
        chk8({4'h0, jack, spk, led, brk}, 8'h0C);
        press = 6'd15;
        fn_press = 1'b1;
        tape_lvl = 1'b1;
        for (int c = 0; c < 6; c++)
        begin
            bus(16'h0002, 1, 8'(1 << c));
            chk8({2'h0, col}, 8'(1 << c));
            bus(16'h0000, 0, 8'h00);
            chk8(r, (c == 3) ? 8'hBB : 8'hBF);
        end
        chk8({7'h0, spk}, 8'h00);
        load = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            tape_lvl = i[0];
            tk(3);
            chk8({7'h0, spk}, {7'h0, i[0]});
        end
        load = 1'b0;
        save = 1'b1;
        bus(16'h0002, 1, 8'h84);
        chk8(seg, 8'h00);
        chk8({2'h0, col}, 8'h00);
        chk8({5'h0, jack, spk, led}, 8'h06);
        bus(16'h0002, 1, 8'h04);
        chk8({4'h0, col[2], jack, spk, led}, 8'h01);
        save = 1'b0;
        tk(1);
        chk8({2'h0, col}, 8'h04);
        foreach (io_a[i])
        begin
            bus({8'h00, io_a[i]}, 0, 8'h00);
            chk8({2'h0, s}, {2'h0, io_a[i][7:6] != 2'h1 && io_a[i][7:6] != 2'h2, 3'h7,
                io_a[i][7:6] != 2'h1, io_a[i][7:6] != 2'h2});
        end
        foreach (mem_a[i])
        begin
            bus(mem_a[i], 2, 8'h00);
            chk8({3'h0, s[4:0]}, {3'h0, mem_e[i], 2'h3});
            if (mem_e[i] == 3'h7)
            begin
                chk8(r, 8'hFF);
            end
        end
        bus(16'h0038, 3, 8'h00);
        chk8(r, 8'hFF);
        bus(16'h00C1, 0, 8'h00);
        chk8(r, 8'hFF);
        bus(16'h0003, 0, 8'h00);
        chk8(r, 8'hFF);
        for (int t = 0; t < 2; t++)
        begin
            pulse(clr);
            for (int b = 0; b < 8; b++)
            begin
                chk8({7'h0, hdr}, {7'h0, b >= 6});
                tbyte = 8'(b * 16 + 3);
                pulse(stb);
            end
            texp = 8'hD6 + 8'(t);
            pulse(done);
            chk8({6'h0, ok, err}, (t == 0) ? 8'h02 : 8'h01);
        end
        pulse(show);
        cnt = 0;
        for (int i = 0; i < HOLD + 10; i++)
        begin
            cnt += (hold === 1'b1);
            tk(1);
        end
        chk8(8'(cnt), 8'(HOLD));
        wrap_up();
    end
endmodule // tb_top
